// file: rtl/snit_defs.svh
`ifndef SNIT_DEFS_SVH
`define SNIT_DEFS_SVH
// node registers, addressed by the frame address byte
`define SNIT_R_CGAIN 8'h10
`define SNIT_R_COFF 8'h18
`define SNIT_R_AGAIN 8'h20
`define SNIT_R_AOFF 8'h28
`define SNIT_R_CMDA 8'h30
`define SNIT_R_CFG 8'h31
`define SNIT_R_UID 8'h32
`define SNIT_R_SID 8'h33
`define SNIT_R_IDST 8'h34
`define SNIT_R_CKS 8'h35
`define SNIT_R_CONV 8'h36
`define SNIT_NCH 6
// field positions
`define SNIT_B_WEN 0
`define SNIT_B_CKUPD 1
`define SNIT_B_STRAP 2
`define SNIT_B_UPD 7
// reset values
`define SNIT_CTRIM_RST 8'h00
`define SNIT_ATRIM_RST 10'h000
`define SNIT_CFG_RST 8'h00
`define SNIT_CONV_RST 16'h0000
// chain role codes
`define SNIT_ROLE_BASE 16'h0000
`define SNIT_ROLE_MID 16'h0002
`define SNIT_ROLE_TOP 16'h0003
// converter setup for calibration: 1 MHz, decimation 256, 1.2 Hz
`define SNIT_CONV_CAL 16'h00ed
// gain: one code is 0.15 mV at 5 V, close to 2^-15 of full scale
`define SNIT_GAIN_SHIFT 15
`define SNIT_GAIN_STEP_UV 150
`define SNIT_CODE_MAX 8'h7f
`define SNIT_CODE_MIN 8'h80
// host registers, byte addresses
`define SNIT_A_CMD 8'h00
`define SNIT_A_HDR 8'h04
`define SNIT_A_DATA 8'h08
`define SNIT_A_CNT 8'h0c
`define SNIT_A_STAT 8'h10
`define SNIT_A_GERR 8'h14
`define SNIT_A_GCODE 8'h18
`define SNIT_CNT_RST 8'h01
`define SNIT_RSP_TMO 8'd16
`define SNIT_RESP_OK 2'b00
`define SNIT_RESP_ERR 2'b10
`endif

// file: rtl/snit_pkg.sv
`default_nettype none
package snit_pkg;
	typedef enum logic [1:0] {
		SNIT_K_NONE = 2'b00,
		SNIT_K_WR   = 2'b01,
		SNIT_K_BC   = 2'b10,
		SNIT_K_RD   = 2'b11
	} snit_kind_e;
	typedef struct packed {
		snit_kind_e  kind;
		logic [5:0]  dev;
		logic [7:0]  addr;
		logic [15:0] data;
	} snit_frame_s;
	typedef logic [5:0][15:0] snit_chan_t;
	typedef enum logic [1:0] {
		SNIT_OP_NONE   = 2'b00,
		SNIT_OP_FRAME  = 2'b01,
		SNIT_OP_ASSIGN = 2'b10,
		SNIT_OP_CAL    = 2'b11
	} snit_op_e;
	typedef enum logic [1:0] {
		SNIT_S_IDLE = 2'b00,
		SNIT_S_SEND = 2'b01,
		SNIT_S_WAIT = 2'b10
	} snit_hst_e;
endpackage : snit_pkg
`default_nettype wire

// file: rtl/snit_if.sv
`timescale 1ns/1ps
`default_nettype none
interface snit_if;
	logic                 frmValid;
	snit_pkg::snit_frame_s frm;
	logic                 rspValid;
	logic [15:0]          rspData;
	modport node (input frmValid, input frm, output rspValid, output rspData);
	modport host (output frmValid, output frm, input rspValid, input rspData);
endinterface : snit_if
`default_nettype wire

// file: rtl/snit_node.sv
// Operation
// - signed 8-bit gain trim per cell channel
// - signed 8-bit offset trim per cell channel
// - zero trim leaves result uncorrected
// - user trim follows factory corrected value
// - host saturates codes to 7F or 80
// - host gain code is negated error over step
// - host sets converter for calibration first
// - auxiliary channels get signed 10-bit trims
// - host refreshes checksum after trim change
// - node id loaded from stored id at reset
// - host gives every node distinct id
// - duplicate ids break reads to them
// - auto assignment when strap off, enable set
// - block forwarding one frame, open id writes
// - next frame clears enable, locks id
// - id status shows new id afterwards
// - transmitter back on after enable clears
// - host starts assignment only with stack awake
// - host broadcasts enable, then consecutive ids
// - host writes roles, top gets checksum update
// - host reads back ids to confirm
`timescale 1ns/1ps
`default_nettype none
`include "snit_defs.svh"
module snit_node (
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 sys_rst,
	// chain link from the base side
	snit_if.node                      lnk,
	// one-time memory image
	input  wire logic [5:0]           otpId,
	// converter results, factory corrections already applied
	input  wire snit_pkg::snit_chan_t cellRaw,
	input  wire snit_pkg::snit_chan_t auxRaw,
	// trimmed results
	output var  snit_pkg::snit_chan_t cellOut,
	output var  snit_pkg::snit_chan_t auxOut,
	// frames passed on to the next node
	output logic                      upValid,
	output var  snit_pkg::snit_frame_s upFrm,
	output logic                      txOn,
	// node state
	output logic [5:0]                nodeId,
	output logic [5:0]                storedId,
	output logic [1:0]                chainRole,
	output logic [15:0]               convCfg,
	output logic [7:0]                cksum
);
	import snit_pkg::*;

	logic [5:0][7:0] cGain_r;
	logic [5:0][7:0] cOff_r;
	logic [5:0][9:0] aGain_r;
	logic [5:0][9:0] aOff_r;
	logic            wen_r;
	logic            upd_r;
	logic            loadPend_r;
	logic [7:0]      cfg_r;
	logic [7:0]      cksNxt;
	logic            wrHit;
	logic            rdHit;
	logic            autoNow;
	logic            rspValid_r;
	logic [15:0]     rspData_r;

	// offset code and raw lsb share one weight; gain is a fraction of the raw value
	function automatic logic [15:0] trimFn(
		input logic [15:0]        raw,
		input logic signed [9:0]  g,
		input logic signed [9:0]  o
	);
		logic signed [27:0] p;
		logic signed [18:0] s;
		p = $signed({1'b0, raw}) * g;
		s = $signed({3'b000, raw}) + 19'(p >>> `SNIT_GAIN_SHIFT) + 19'(o);
		if (s[18])
			trimFn = 16'h0000;
		else if (|s[17:16])
			trimFn = 16'hffff;
		else
			trimFn = s[15:0];
	endfunction : trimFn

	// trim block index, or 3'h7 when the address is outside that block
	function automatic logic [2:0] chIdx(input logic [7:0] a, input logic [7:0] base);
		if (a[7:3] == base[7:3] && a[2:0] < 3'(`SNIT_NCH))
			chIdx = a[2:0];
		else
			chIdx = 3'h7;
	endfunction : chIdx

	function automatic logic [15:0] rdMux(input logic [7:0] a);
		rdMux = 16'h0000;
		if (chIdx(a, `SNIT_R_CGAIN) != 3'h7)
			rdMux = {8'h00, cGain_r[chIdx(a, `SNIT_R_CGAIN)]};
		else if (chIdx(a, `SNIT_R_COFF) != 3'h7)
			rdMux = {8'h00, cOff_r[chIdx(a, `SNIT_R_COFF)]};
		else if (chIdx(a, `SNIT_R_AGAIN) != 3'h7)
			rdMux = {6'h00, aGain_r[chIdx(a, `SNIT_R_AGAIN)]};
		else if (chIdx(a, `SNIT_R_AOFF) != 3'h7)
			rdMux = {6'h00, aOff_r[chIdx(a, `SNIT_R_AOFF)]};
		else
		begin
			case (a)
				`SNIT_R_CMDA: rdMux = {15'h0000, wen_r};
				`SNIT_R_CFG:  rdMux = {8'h00, cfg_r};
				`SNIT_R_UID:  rdMux = {10'h000, nodeId};
				`SNIT_R_SID:  rdMux = {10'h000, storedId};
				`SNIT_R_IDST: rdMux = {8'h00, upd_r, 1'b0, nodeId};
				`SNIT_R_CKS:  rdMux = {8'h00, cksum};
				`SNIT_R_CONV: rdMux = convCfg;
				default:      rdMux = 16'h0000;
			endcase
		end
	endfunction : rdMux

	assign autoNow = wen_r && !cfg_r[`SNIT_B_STRAP];
	assign wrHit = lnk.frmValid && (lnk.frm.kind == SNIT_K_BC
		|| (lnk.frm.kind == SNIT_K_WR && lnk.frm.dev == nodeId));
	assign rdHit = lnk.frmValid && lnk.frm.kind == SNIT_K_RD && lnk.frm.dev == nodeId;
	assign lnk.rspValid = rspValid_r;
	assign lnk.rspData = rspData_r;
	assign chainRole = cfg_r[1:0];

	// checksum folds every byte that would be burnt to one-time memory
	always_comb
	begin
		cksNxt = {2'b00, nodeId} ^ cfg_r;
		for (int i = 0; i < `SNIT_NCH; i++)
		begin
			cksNxt = cksNxt ^ cGain_r[i] ^ cOff_r[i] ^ aGain_r[i][7:0] ^ aOff_r[i][7:0]
				^ {4'h0, aGain_r[i][9:8], aOff_r[i][9:8]};
		end
	end

	always_ff @(posedge mclk)
	begin
		for (int i = 0; i < `SNIT_NCH; i++)
		begin
			if (sys_rst)
			begin
				cGain_r[i] <= `SNIT_CTRIM_RST;
				cOff_r[i] <= `SNIT_CTRIM_RST;
				aGain_r[i] <= `SNIT_ATRIM_RST;
				aOff_r[i] <= `SNIT_ATRIM_RST;
			end
			else if (wrHit && !autoNow)
			begin
				if (lnk.frm.addr == `SNIT_R_CGAIN + 8'(i))
					cGain_r[i] <= lnk.frm.data[7:0];
				if (lnk.frm.addr == `SNIT_R_COFF + 8'(i))
					cOff_r[i] <= lnk.frm.data[7:0];
				if (lnk.frm.addr == `SNIT_R_AGAIN + 8'(i))
					aGain_r[i] <= lnk.frm.data[9:0];
				if (lnk.frm.addr == `SNIT_R_AOFF + 8'(i))
					aOff_r[i] <= lnk.frm.data[9:0];
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		for (int i = 0; i < `SNIT_NCH; i++)
		begin
			if (sys_rst)
			begin
				cellOut[i] <= 16'h0000;
				auxOut[i] <= 16'h0000;
			end
			else
			begin
				cellOut[i] <= trimFn(cellRaw[i], {{2{cGain_r[i][7]}}, cGain_r[i]},
					{{2{cOff_r[i][7]}}, cOff_r[i]});
				auxOut[i] <= trimFn(auxRaw[i], aGain_r[i], aOff_r[i]);
			end
		end
	end

	// id handling; async-free reset, the memory image is taken one edge after release
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			loadPend_r <= 1'b1;
			nodeId <= 6'h00;
			storedId <= 6'h00;
			wen_r <= 1'b0;
			upd_r <= 1'b0;
		end
		else if (loadPend_r)
		begin
			loadPend_r <= 1'b0;
			nodeId <= otpId;
			storedId <= otpId;
		end
		else if (lnk.frmValid && autoNow)
		begin
			wen_r <= 1'b0;
			if (wrHit && lnk.frm.addr == `SNIT_R_UID)
			begin
				nodeId <= lnk.frm.data[5:0];
				upd_r <= 1'b1;
			end
		end
		else if (wrHit)
		begin
			// user id write needs auto mode
			if (lnk.frm.addr == `SNIT_R_CMDA)
				wen_r <= lnk.frm.data[`SNIT_B_WEN];
			if (lnk.frm.addr == `SNIT_R_SID)
				storedId <= lnk.frm.data[5:0];
		end
	end

	// configuration, converter setup and checksum
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			cfg_r <= `SNIT_CFG_RST;
			convCfg <= `SNIT_CONV_RST;
			cksum <= 8'h00;
		end
		else if (wrHit && !autoNow)
		begin
			if (lnk.frm.addr == `SNIT_R_CFG)
				cfg_r <= lnk.frm.data[7:0];
			if (lnk.frm.addr == `SNIT_R_CONV)
				convCfg <= lnk.frm.data;
			if (lnk.frm.addr == `SNIT_R_CMDA && lnk.frm.data[`SNIT_B_CKUPD])
				cksum <= cksNxt;
		end
	end

	// frame during auto mode is not forwarded
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			upValid <= 1'b0;
			upFrm <= '0;
			txOn <= 1'b1;
		end
		else
		begin
			upValid <= lnk.frmValid && !autoNow;
			upFrm <= lnk.frm;
			txOn <= !autoNow;
		end
	end

	// every node holding the id answers, so twins collide
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rspValid_r <= 1'b0;
			rspData_r <= 16'h0000;
		end
		else
		begin
			rspValid_r <= rdHit && !loadPend_r;
			rspData_r <= rdHit ? rdMux(lnk.frm.addr) : 16'h0000;
		end
	end
endmodule : snit_node
`default_nettype wire

// file: rtl/snit_host.sv
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "snit_defs.svh"
module snit_host (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// AXI4-Lite slave
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// stack wake state, same clock
	input  wire logic        stackAwake,
	// chain link toward the node
	snit_if.host             lnk
);
	import snit_pkg::*;

	snit_hst_e   state_r;
	snit_op_e    op_r;
	snit_op_e    cmdOp_r;
	logic        cmdGo_r;
	logic [17:0] hdr_r;
	logic [15:0] data_r;
	logic [7:0]  cnt_r;
	logic [7:0]  step_r;
	logic [7:0]  tmo_r;
	logic        fail_r;
	logic [15:0] rsp_r;
	logic [7:0]  gcode_r;
	logic        frmValid_r;
	snit_frame_s frm_r;
	snit_frame_s cur;
	logic [7:0]  last;
	logic        wrTaken;

	function automatic logic [7:0] sat8(input logic signed [31:0] v);
		if (v > 32'sd127)
			sat8 = `SNIT_CODE_MAX;
		else if (v < -32'sd128)
			sat8 = `SNIT_CODE_MIN;
		else
			sat8 = v[7:0];
	endfunction : sat8

	function automatic logic isTrim(input logic [7:0] a);
		isTrim = a[7:4] == 4'h1 || a[7:4] == 4'h2;
	endfunction : isTrim

	function automatic snit_frame_s stepFrame(input snit_op_e op, input logic [7:0] s);
		snit_frame_s f;
		logic [7:0]  k;
		f = '{kind: SNIT_K_BC, dev: 6'h00, addr: `SNIT_R_CMDA, data: 16'h0001};
		k = 8'h00;
		case (op)
			SNIT_OP_FRAME:
			begin
				f = '{kind: snit_kind_e'(hdr_r[17:16]), dev: hdr_r[13:8], addr: hdr_r[7:0],
					data: data_r};
				// follow trim write with checksum update
				if (s != 8'h00)
				begin
					f.addr = `SNIT_R_CMDA;
					f.data = 16'h0002;
				end
			end
			SNIT_OP_ASSIGN:
			begin
				if (s != 8'h00 && s <= cnt_r)
				begin
					f.addr = `SNIT_R_UID;
					f.data = {8'h00, s - 8'h01};
				end
				else if (s != 8'h00 && s <= 8'(cnt_r << 1))
				begin
					k = s - cnt_r - 8'h01;
					f = '{kind: SNIT_K_WR, dev: k[5:0], addr: `SNIT_R_CFG,
						data: k == 8'h00 ? `SNIT_ROLE_BASE
						: k == cnt_r - 8'h01 ? `SNIT_ROLE_TOP : `SNIT_ROLE_MID};
				end
				else if (s == 8'(cnt_r << 1) + 8'h01)
				begin
					k = cnt_r - 8'h01;
					f = '{kind: SNIT_K_WR, dev: k[5:0], addr: `SNIT_R_CMDA, data: 16'h0002};
				end
				else if (s != 8'h00)
				begin
					k = s - 8'(cnt_r << 1) - 8'h02;
					f = '{kind: SNIT_K_RD, dev: k[5:0], addr: `SNIT_R_IDST, data: 16'h0000};
				end
			end
			SNIT_OP_CAL:
			begin
				f.addr = `SNIT_R_CONV;
				f.data = `SNIT_CONV_CAL;
			end
			default: f.kind = SNIT_K_NONE;
		endcase
		stepFrame = f;
	endfunction : stepFrame

	assign cur = stepFrame(op_r, step_r);
	assign last = op_r == SNIT_OP_ASSIGN ? 8'(cnt_r * 8'h03) + 8'h01
		: (op_r == SNIT_OP_FRAME && hdr_r[17:16] != 2'(SNIT_K_RD) && isTrim(hdr_r[7:0]))
		? 8'h01 : 8'h00;
	assign lnk.frmValid = frmValid_r;
	assign lnk.frm = frm_r;
	assign wrTaken = awvalid && awready;

	// write channel: both address and data are taken on the same edge
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `SNIT_RESP_OK;
			cmdGo_r <= 1'b0;
			cmdOp_r <= SNIT_OP_NONE;
			hdr_r <= 18'h00000;
			data_r <= 16'h0000;
			cnt_r <= `SNIT_CNT_RST;
			gcode_r <= 8'h00;
		end
		else
		begin
			cmdGo_r <= 1'b0;
			awready <= awvalid && wvalid && !awready && !bvalid;
			wready <= awvalid && wvalid && !awready && !bvalid;
			if (bvalid && bready)
				bvalid <= 1'b0;
			if (wrTaken)
			begin
				bvalid <= 1'b1;
				bresp <= `SNIT_RESP_OK;
				case (awaddr)
					`SNIT_A_CMD:
					begin
						cmdGo_r <= wstrb[0];
						cmdOp_r <= snit_op_e'(wdata[1:0]);
					end
					`SNIT_A_HDR: hdr_r <= {wdata[17:16], 2'b00, wdata[13:0]};
					`SNIT_A_DATA: data_r <= wdata[15:0];
					`SNIT_A_CNT: cnt_r <= wdata[6:0] > 7'd64 ? 8'd64 : {1'b0, wdata[6:0]};
					// code is negated error over gain step
					`SNIT_A_GERR: gcode_r <= sat8(-$signed(wdata) / `SNIT_GAIN_STEP_UV);
					default: bresp <= `SNIT_RESP_ERR;
				endcase
			end
		end
	end

	// read channel
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `SNIT_RESP_OK;
		end
		else
		begin
			arready <= arvalid && !arready && !rvalid;
			if (rvalid && rready)
				rvalid <= 1'b0;
			if (arvalid && arready)
			begin
				rvalid <= 1'b1;
				rresp <= `SNIT_RESP_OK;
				case (araddr)
					`SNIT_A_HDR: rdata <= {14'h0000, hdr_r};
					`SNIT_A_DATA: rdata <= {16'h0000, data_r};
					`SNIT_A_CNT: rdata <= {24'h000000, cnt_r};
					`SNIT_A_STAT: rdata <= {rsp_r, 14'h0000, fail_r,
						state_r != SNIT_S_IDLE || cmdGo_r};
					`SNIT_A_GCODE: rdata <= {24'h000000, gcode_r};
					`SNIT_A_CMD: rdata <= {30'h00000000, op_r};
					default:
					begin
						rdata <= 32'h00000000;
						rresp <= `SNIT_RESP_ERR;
					end
				endcase
			end
		end
	end

	// frame sequencer; a new command is ignored while busy
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			state_r <= SNIT_S_IDLE;
			op_r <= SNIT_OP_NONE;
			step_r <= 8'h00;
			tmo_r <= 8'h00;
			fail_r <= 1'b0;
			rsp_r <= 16'h0000;
			frmValid_r <= 1'b0;
			frm_r <= '0;
		end
		else
		begin
			frmValid_r <= 1'b0;
			case (state_r)
				SNIT_S_IDLE:
				begin
					if (cmdGo_r && cmdOp_r != SNIT_OP_NONE)
					begin
						op_r <= cmdOp_r;
						step_r <= 8'h00;
						fail_r <= cmdOp_r == SNIT_OP_ASSIGN && !stackAwake;
						if (cmdOp_r != SNIT_OP_ASSIGN || stackAwake)
							state_r <= SNIT_S_SEND;
					end
				end
				SNIT_S_SEND:
				begin
					frmValid_r <= 1'b1;
					frm_r <= cur;
					tmo_r <= 8'h00;
					if (cur.kind == SNIT_K_RD)
						state_r <= SNIT_S_WAIT;
					else if (step_r == last)
						state_r <= SNIT_S_IDLE;
					else
						step_r <= step_r + 8'h01;
				end
				SNIT_S_WAIT:
				begin
					tmo_r <= tmo_r + 8'h01;
					if (lnk.rspValid || tmo_r == `SNIT_RSP_TMO)
					begin
						rsp_r <= lnk.rspValid ? lnk.rspData : 16'h0000;
						if (!lnk.rspValid || (op_r == SNIT_OP_ASSIGN
							&& lnk.rspData[5:0] != frm_r.dev))
							fail_r <= 1'b1;
						step_r <= step_r + 8'h01;
						state_r <= step_r == last ? SNIT_S_IDLE : SNIT_S_SEND;
					end
				end
				default: state_r <= SNIT_S_IDLE;
			endcase
		end
	end
endmodule : snit_host
`default_nettype wire

// file: test/snit_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "snit_defs.svh"
module snit_chk (
	// clock and reset
	input wire logic                  mclk,
	input wire logic                  sys_rst,
	// chain link
	input wire logic                  frmValid,
	input wire snit_pkg::snit_frame_s frm,
	input wire logic                  rspValid,
	input wire logic [15:0]           rspData,
	// node state
	input wire logic                  upValid,
	input wire logic                  txOn,
	input wire logic [5:0]            nodeId,
	input wire logic [5:0]            otpId
);
	import snit_pkg::*;
	logic [5:0] lastData_r;
	logic       lastUid_r;
	logic       lastRd_r;
	// helper copies of the previous frame, no reset needed
	always_ff @(posedge mclk) lastData_r <= frm.data[5:0];
	always_ff @(posedge mclk) lastUid_r <= frmValid && frm.addr == `SNIT_R_UID;
	always_ff @(posedge mclk) lastRd_r <= frmValid && frm.kind == SNIT_K_RD && frm.dev == nodeId;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	sequence sWenSet;
		frmValid && frm.kind == SNIT_K_BC && frm.addr == `SNIT_R_CMDA && frm.data[`SNIT_B_WEN];
	endsequence
	sequence sBlocked;
		sWenSet ##1 frmValid;
	endsequence
	chk_wen_blocks: assert property (sBlocked |=> !upValid)
		else $error("frame after id enable was forwarded");
	chk_tx_off: assert property (sWenSet |=> ##1 !txOn)
		else $error("transmitter stayed on after id enable");
	chk_id_locked: assert property (sBlocked ##0 (frm.kind == SNIT_K_BC &&
		frm.addr == `SNIT_R_UID) |=> nodeId == lastData_r)
		else $error("node id not taken from assignment frame");
	chk_tx_back: assert property (sBlocked |=> ##1 txOn)
		else $error("transmitter not back on after assignment");
	chk_otp_load: assert property ($fell(sys_rst) |=> nodeId == otpId)
		else $error("node id not loaded from stored image");
	chk_id_source: assert property ($changed(nodeId) |->
		$past(sys_rst) || $past(sys_rst, 2) || lastUid_r)
		else $error("node id changed without cause");
	chk_rsp_read: assert property (frmValid && frm.kind == SNIT_K_RD &&
		frm.dev == nodeId |=> rspValid)
		else $error("read to own id got no answer");
	chk_rsp_cause: assert property (rspValid |-> lastRd_r)
		else $error("answer without a matching read");
	chk_stat_id: assert property (frmValid && frm.kind == SNIT_K_RD && frm.dev == nodeId &&
		frm.addr == `SNIT_R_IDST |=> rspData[5:0] == nodeId)
		else $error("id status does not show node id");
	cover property (sBlocked);
endmodule : snit_chk
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "snit_defs.svh"
module tb;
	import snit_pkg::*;
	logic              mclk = 0;
	logic              sys_rst = 1;
	logic [7:0]        awaddr = 0;
	logic [7:0]        araddr = 0;
	logic              awvalid = 0;
	logic              wvalid = 0;
	logic              bready = 0;
	logic              arvalid = 0;
	logic              rready = 0;
	logic              stackAwake = 1;
	logic [31:0]       wdata = 0;
	logic [5:0]        otpId = 0;
	snit_chan_t        cellRaw = '0;
	snit_chan_t        auxRaw = '0;
	logic              awready, wready, bvalid, arready, rvalid, upValid, txOn;
	logic [1:0]        bresp, rresp, chainRole, rs;
	logic [31:0]       rdata, rd;
	logic [5:0]        nodeId, storedId, idExp;
	snit_chan_t        cellOut, auxOut;
	snit_frame_s       upFrm;
	logic [15:0]       convCfg;
	logic [7:0]        cksum;
	logic signed [9:0] gT [12];
	logic signed [9:0] oT [12];
	int                nErrors = 0;
	int                nTests = 0;
	int                cyc = 0;
	snit_if snit_if_i ();
	snit_host snit_host_i (.mclk, .sys_rst, .awaddr, .awvalid, .awready, .wdata,
		.wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .stackAwake, .lnk(snit_if_i));
	snit_node snit_node_i (.mclk, .sys_rst, .lnk(snit_if_i), .otpId, .cellRaw, .auxRaw,
		.cellOut, .auxOut, .upValid, .upFrm, .txOn, .nodeId, .storedId, .chainRole,
		.convCfg, .cksum);
	snit_chk snit_chk_i (.mclk, .sys_rst, .frmValid(snit_if_i.frmValid), .frm(snit_if_i.frm),
		.rspValid(snit_if_i.rspValid), .rspData(snit_if_i.rspData), .upValid, .txOn,
		.nodeId, .otpId);
	always #50 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			nErrors++;
			summarize();
		end
	end
	task summarize;
		$display("errors %0d checks %0d", nErrors, nTests);
		if (nErrors == 0 && nTests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// write address and write data may be taken in either order
	task axw(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 0;
		w = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		while (!(aw && w))
		begin
			@(posedge mclk);
			if (awready) begin aw = 1; awvalid <= 0; end
			if (wready) begin w = 1; wvalid <= 0; end
		end
		bready <= 1;
		do @(posedge mclk); while (!bvalid);
		rs = bresp;
		bready <= 0;
	endtask : axw
	task axr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1;
		do @(posedge mclk); while (!arready);
		arvalid <= 0;
		rready <= 1;
		do @(posedge mclk); while (!rvalid);
		rd = rdata;
		rs = rresp;
		rready <= 0;
	endtask : axr
	task waitIdle;
		do axr(`SNIT_A_STAT); while (rd[0] !== 1'b0);
	endtask : waitIdle
	task frame(input logic [1:0] k, input logic [7:0] a, input logic [15:0] d);
		axw(`SNIT_A_HDR, {14'h0, k, 2'h0, idExp, a});
		axw(`SNIT_A_DATA, {16'h0, d});
		axw(`SNIT_A_CMD, 32'h1);
		waitIdle();
	endtask : frame
	task doReset(input logic [5:0] id);
		sys_rst <= 1;
		otpId <= id;
		idExp = id;
		repeat (16) @(posedge mclk);
		sys_rst <= 0;
		repeat (3) @(posedge mclk);
		check("nodeId", nodeId, id);
		check("storedId", storedId, id);
	endtask : doReset
	function automatic logic [15:0] trimF(logic [15:0] r, logic signed [9:0] g, o);
		logic signed [31:0] v;
		v = $signed({16'h0, r}) + (($signed({16'h0, r}) * g) >>> 15) + o;
		return (v < 0) ? 16'h0 : (v > 32'sh0000ffff) ? 16'hffff : v[15:0];
	endfunction : trimF
	function automatic logic [7:0] satF(int e);
		int q;
		q = -e / 150;
		return (q > 127) ? `SNIT_CODE_MAX : (q < -128) ? `SNIT_CODE_MIN : 8'(q);
	endfunction : satF
	// mode 0 zero trims, 1 random, 2 extremes driving both clamps on the cell channels
	task trimRound(input int mode);
		logic [7:0] ck;
		for (int i = 0; i < 12; i++)
		begin
			int lim;
			lim = (i < 6) ? 128 : 512;
			gT[i] = 10'(mode == 0 ? 0 : mode == 1 ? int'($urandom_range(2 * lim - 1)) - lim :
				(i % 2) ? lim - 1 : -lim);
			oT[i] = 10'(mode == 0 ? 0 : mode == 1 ? int'($urandom_range(2 * lim - 1)) - lim :
				(i % 2) ? lim - 1 : -lim);
			frame(SNIT_K_WR, 8'(i < 6 ? `SNIT_R_CGAIN + i : `SNIT_R_AGAIN + i - 6),
				{{6{gT[i][9]}}, gT[i]});
			frame(SNIT_K_WR, 8'(i < 6 ? `SNIT_R_COFF + i : `SNIT_R_AOFF + i - 6),
				{{6{oT[i][9]}}, oT[i]});
		end
		for (int i = 0; i < 6; i++)
		begin
			cellRaw[i] <= (mode == 2) ? ((i % 2) ? 16'hffff : 16'h0) : 16'($urandom);
			auxRaw[i] <= (mode == 2) ? ((i % 2) ? 16'h0 : 16'hffff) : 16'($urandom);
		end
		repeat (3) @(posedge mclk);
		for (int i = 0; i < 6; i++)
		begin
			check("cellOut", cellOut[i], trimF(cellRaw[i], gT[i], oT[i]));
			check("auxOut", auxOut[i], trimF(auxRaw[i], gT[i + 6], oT[i + 6]));
		end
		// every trim write is followed by a checksum refresh, so the fold covers them all
		ck = {2'b00, idExp};
		for (int i = 0; i < 12; i++)
			ck = ck ^ gT[i][7:0] ^ oT[i][7:0] ^ ((i < 6) ? 8'h00 : {4'h0, gT[i][9:8], oT[i][9:8]});
		check("cksum", cksum, ck);
		$display("test trims mode %0d finished", mode);
	endtask : trimRound
	initial
	begin
		int ge [5];
		int e;
		ge = '{-19050, -19200, 19350, 150, 0};
		void'($urandom(36177));
		doReset(6'($urandom_range(63, 1)));
		for (int m = 0; m < 3; m++)
			trimRound(m);
		for (int i = 0; i < 10; i++)
		begin
			e = (i < 5) ? ge[i] : (int'($urandom_range(400)) - 200) * 150;
			axw(`SNIT_A_GERR, e);
			axr(`SNIT_A_GCODE);
			check("gcode", rd[7:0], satF(e));
		end
		axw(8'h1c, 32'h0);
		check("bresp", rs, `SNIT_RESP_ERR);
		axr(8'h1c);
		check("rdata", rd, 32'h0);
		check("rresp", rs, `SNIT_RESP_ERR);
		axw(`SNIT_A_CMD, 32'h3);
		waitIdle();
		check("convCfg", convCfg, `SNIT_CONV_CAL);
		frame(SNIT_K_WR, `SNIT_R_UID, 16'h0015);
		check("nodeId", nodeId, idExp);
		check("upFrm", upFrm, {SNIT_K_WR, idExp, `SNIT_R_UID, 16'h0015});
		// strap selected: enable alone must not open id writes
		frame(SNIT_K_WR, `SNIT_R_CFG, 16'h0004);
		frame(SNIT_K_WR, `SNIT_R_CMDA, 16'h0001);
		frame(SNIT_K_BC, `SNIT_R_UID, 16'h0015);
		check("nodeId", nodeId, idExp);
		check("txOn", txOn, 1'b1);
		// clear enable before the strap, or auto mode would start at once
		frame(SNIT_K_WR, `SNIT_R_CMDA, 16'h0000);
		frame(SNIT_K_WR, `SNIT_R_CFG, 16'h0000);
		stackAwake <= 0;
		axw(`SNIT_A_CMD, 32'h2);
		waitIdle();
		check("fail", rd[1], 1'b1);
		check("nodeId", nodeId, idExp);
		stackAwake <= 1;
		$display("test host and id guard finished");
		axw(`SNIT_A_CNT, 32'h1);
		axw(`SNIT_A_CMD, 32'h2);
		waitIdle();
		check("stat", {rd[31:16], rd[1:0]}, {16'h0080, 2'b00});
		check("nodeId", nodeId, 6'h0);
		check("chainRole", chainRole, 2'b00);
		doReset(6'($urandom_range(63, 1)));
		axw(`SNIT_A_CNT, 32'h3);
		axw(`SNIT_A_CMD, 32'h2);
		waitIdle();
		check("fail", rd[1], 1'b1);
		check("nodeId", nodeId, 6'h0);
		$display("test assignment finished");
		summarize();
	end
endmodule : tb
`default_nettype wire
